/* File: logic/reu_defs.svh */
`ifndef REU_DEFS_SVH
`define REU_DEFS_SVH
// wishbone word offsets (byte addresses)
`define REU_FUNC_THRESH_ADDR 8'h00
`define REU_DEST_THRESH_ADDR 8'h04
`define REU_COUNTERS_ADDR 8'h08
`define REU_CLEAR_ADDR 8'h0C
`define REU_ALT_REACT_ADDR 8'h10
`define REU_PERIPH_RST_ADDR 8'h14
`define REU_CAUSE_ADDR 8'h18
`define REU_IRQ_STAT_ADDR 8'h1C
`define REU_IRQ_MASK_ADDR 8'h20
`define REU_STC_KEY_ADDR 8'h24
`define REU_STC_CTRL_ADDR 8'h28
`define REU_STC_STAT_ADDR 8'h2C
`define REU_KEY1 32'h5AF0_5AF0
`define REU_KEY2 32'hA50F_A50F
// clear register bits
`define REU_CLR_FUNC_BIT 0
`define REU_CLR_DEST_BIT 1
// cause bits
`define REU_CAUSE_POR 0
`define REU_CAUSE_EXT 1
`define REU_CAUSE_DEST 2
`define REU_CAUSE_FUNC 3
`define REU_CAUSE_ESC 4
`define REU_CAUSE_SAFE 5
// self-test control bits
`define REU_STC_RUN_BIT 0
`define REU_STC_INJ_UF_BIT 1
`define REU_STC_INJ_RF_BIT 2
// self-test status bits
`define REU_STC_BUSY_BIT 0
`define REU_STC_FAIL_BIT 1
// event sources
`define REU_NUM_SRC 4
// reset pulse and self-test down-counter loads; each phase lasts one cycle more
`define REU_RST_PULSE_CYC 8'h04
`define REU_TEST_CYC 8'h10
`endif

/* File: logic/reu_if.sv */
`include "reu_defs.svh"
interface reu_if;
	logic [`REU_NUM_SRC-1:0] funcEvent; // functional reset requests
	logic extReset; // external reset request
	logic stcDestReq; // self-test asks for destructive reset
	logic stcUnrecFault; // unrecoverable fault line
	logic stcRecFault; // recoverable fault line
	logic stcRunning; // self-test in progress
	logic stcStart; // start self-test pulse
	logic funcResetOut; // functional reset active
	logic destResetOut; // destructive reset active
	logic pinMuxReset; // pin multiplexing unit reset
	modport dev (input funcEvent, input extReset, input stcDestReq, input stcUnrecFault, input stcRecFault,
		input stcRunning, output stcStart, output funcResetOut, output destResetOut, output pinMuxReset);
	modport src (output funcEvent, output extReset, output stcDestReq, output stcUnrecFault,
		output stcRecFault, output stcRunning, input stcStart, input funcResetOut, input destResetOut,
		input pinMuxReset);
endinterface

/* File: logic/reu_pkg.sv */
package reu_pkg;
	typedef enum logic [1:0] {REU_RUN, REU_FRESET, REU_DRESET, REU_LOCKED} reu_state_e;
	typedef logic [7:0] reu_count_t;
endpackage

/* File: logic/reu_reset_unit.sv */
`include "reu_defs.svh"
module reu_reset_unit
	import reu_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // power-on reset
	input wire logic [7:0] wbAdr, // wishbone address
	input wire logic [31:0] wbDatI, // write data
	output logic [31:0] wbDatO, // read data
	input wire logic wbCyc, // cycle
	input wire logic wbStb, // strobe
	input wire logic wbWe, // write enable
	input wire logic [3:0] wbSel, // byte selects
	output logic wbAck, // acknowledge
	output logic wbErr, // error
	output logic irq, // interrupt level
	output logic safeModeReq, // safe mode transition request
	reu_if.dev link // reset sources
);
	reu_state_e state_q;
	reu_count_t funcThresh_q, destThresh_q, funcCnt_q, destCnt_q, pulseCnt_q;
	logic [`REU_NUM_SRC-1:0] altReact_q, funcEvtSeen;
	logic [5:0] cause_q, irqStat_q, irqMask_q, evt;
	logic pinRst_q, keyStage_q, unlocked_q, stcStart_q, injUf_q, injRf_q, stcBusy_q, stcFail_q;
	logic funcResetOut_q, destResetOut_q, irq_q, safeReq_q, safeEvt;
	logic req, rd, wr, hit, keyOk, clrFunc, clrDest, funcIn, destIn, escalate, stcWr, ufSeen, lockNow;
	logic [31:0] rdData;

	function automatic logic selAll(input logic [3:0] s);
		selAll = &s;
	endfunction

	assign req = wbCyc && wbStb && !wbAck && !wbErr;
	assign wr = req && wbWe;
	assign rd = req && !wbWe;
	assign stcWr = wr && (wbAdr == `REU_STC_CTRL_ADDR);
	assign keyOk = unlocked_q && selAll(wbSel);
	assign clrFunc = wr && wbAdr == `REU_CLEAR_ADDR && wbDatI[`REU_CLR_FUNC_BIT];
	assign clrDest = wr && wbAdr == `REU_CLEAR_ADDR && wbDatI[`REU_CLR_DEST_BIT];
	assign ufSeen = link.stcUnrecFault || injUf_q;
	assign funcEvtSeen = link.funcEvent & ~altReact_q;
	assign safeEvt = |(link.funcEvent & altReact_q);
	assign funcIn = state_q == REU_RUN && |funcEvtSeen;
	assign destIn = state_q == REU_RUN && (link.stcDestReq || ufSeen);
	// escalate when the next functional reset reaches a nonzero threshold
	assign escalate = funcIn && funcThresh_q != 8'h00 && funcCnt_q + 8'h01 >= funcThresh_q;
	assign evt = {safeEvt, escalate, funcIn, destIn, link.extReset && state_q == REU_RUN, 1'b0};
	assign lockNow = destThresh_q != 8'h00 && destCnt_q >= destThresh_q;

	always_comb
	begin
		hit = 1'b1;
		case (wbAdr)
			`REU_FUNC_THRESH_ADDR: rdData = {24'h0, funcThresh_q};
			`REU_DEST_THRESH_ADDR: rdData = {24'h0, destThresh_q};
			`REU_COUNTERS_ADDR: rdData = {16'h0, destCnt_q, funcCnt_q};
			`REU_CLEAR_ADDR: rdData = 32'h0;
			`REU_ALT_REACT_ADDR: rdData = {28'h0, altReact_q};
			`REU_PERIPH_RST_ADDR: rdData = {31'h0, pinRst_q};
			`REU_CAUSE_ADDR: rdData = {26'h0, cause_q};
			`REU_IRQ_STAT_ADDR: rdData = {26'h0, irqStat_q};
			`REU_IRQ_MASK_ADDR: rdData = {26'h0, irqMask_q};
			`REU_STC_KEY_ADDR: rdData = {31'h0, unlocked_q};
			`REU_STC_CTRL_ADDR: rdData = {29'h0, injRf_q, injUf_q, 1'b0};
			`REU_STC_STAT_ADDR: rdData = {30'h0, stcFail_q, stcBusy_q};
			default:
			begin
				rdData = 32'h0;
				hit = 1'b0;
			end
		endcase
	end

	// one-cycle answer; unmapped or unkeyed self-test writes end in error
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wbAck <= 1'b0;
			wbErr <= 1'b0;
			wbDatO <= 32'h0;
		end
		else
		begin
			wbAck <= req && hit && !(stcWr && !keyOk);
			wbErr <= req && (!hit || (stcWr && !keyOk));
			// latched with the request so a read-clear cannot change the answer
			if (rd)
				wbDatO <= rdData;
		end
	end

	// two-word key sequence unlocks one self-test control write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			keyStage_q <= 1'b0;
			unlocked_q <= 1'b0;
		end
		else if (wr && wbAdr == `REU_STC_KEY_ADDR)
		begin
			keyStage_q <= wbDatI == `REU_KEY1;
			unlocked_q <= keyStage_q && wbDatI == `REU_KEY2;
		end
		else if (stcWr)
			unlocked_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			funcThresh_q <= 8'h00;
			destThresh_q <= 8'h00;
			altReact_q <= '0;
			pinRst_q <= 1'b0;
			irqMask_q <= '0;
			stcStart_q <= 1'b0;
			injUf_q <= 1'b0;
			injRf_q <= 1'b0;
		end
		else
		begin
			stcStart_q <= 1'b0;
			if (wr && wbAdr == `REU_FUNC_THRESH_ADDR && wbSel[0])
				funcThresh_q <= wbDatI[7:0];
			if (wr && wbAdr == `REU_DEST_THRESH_ADDR && wbSel[0])
				destThresh_q <= wbDatI[7:0];
			if (wr && wbAdr == `REU_ALT_REACT_ADDR && wbSel[0])
				altReact_q <= wbDatI[`REU_NUM_SRC-1:0];
			if (wr && wbAdr == `REU_PERIPH_RST_ADDR && wbSel[0])
				pinRst_q <= wbDatI[0];
			if (wr && wbAdr == `REU_IRQ_MASK_ADDR && wbSel[0])
				irqMask_q <= wbDatI[5:0];
			if (stcWr && keyOk)
			begin
				stcStart_q <= wbDatI[`REU_STC_RUN_BIT];
				injUf_q <= wbDatI[`REU_STC_INJ_UF_BIT];
				injRf_q <= wbDatI[`REU_STC_INJ_RF_BIT];
			end
			// besides keyed software writes, the destructive reset phase restarts the self-test, just before it ends
			if (state_q == REU_DRESET && pulseCnt_q == 8'h01)
				stcStart_q <= 1'b1;
		end
	end

	// reset sequencing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= REU_RUN;
			pulseCnt_q <= 8'h00;
		end
		else
			case (state_q)
				REU_RUN:
					if (destIn || escalate || link.extReset)
					begin
						state_q <= REU_DRESET;
						pulseCnt_q <= `REU_RST_PULSE_CYC;
					end
					else if (funcIn)
					begin
						state_q <= REU_FRESET;
						pulseCnt_q <= `REU_RST_PULSE_CYC;
					end
				REU_FRESET:
					if (pulseCnt_q == 8'h00)
						state_q <= REU_RUN;
					else
						pulseCnt_q <= pulseCnt_q - 8'h01;
				REU_DRESET:
					if (pulseCnt_q == 8'h00)
						state_q <= lockNow ? REU_LOCKED : REU_RUN;
					else
						pulseCnt_q <= pulseCnt_q - 8'h01;
				REU_LOCKED: state_q <= REU_LOCKED;
				default: state_q <= REU_RUN;
			endcase
	end

	// escalation counters
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			funcCnt_q <= 8'h00;
			destCnt_q <= 8'h00;
		end
		else
		begin
			// an event in the same cycle as a software clear is still counted
			if (state_q == REU_RUN && (destIn || escalate || link.extReset))
				funcCnt_q <= 8'h00;
			else if (funcIn && funcThresh_q != 8'h00)
				funcCnt_q <= clrFunc ? 8'h01 : funcCnt_q + 8'h01;
			else if (clrFunc)
				funcCnt_q <= 8'h00;
			if (state_q == REU_RUN && (destIn || escalate || link.extReset) && destCnt_q != 8'hFF)
				destCnt_q <= clrDest ? 8'h01 : destCnt_q + 8'h01;
			else if (clrDest)
				destCnt_q <= 8'h00;
		end
	end

	// destructive reset output held during the destructive pulse phase and for good once locked
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			destResetOut_q <= 1'b0;
		else
			destResetOut_q <= state_q == REU_DRESET || state_q == REU_LOCKED;
	end

	// self-test status tracking
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stcBusy_q <= 1'b0;
			stcFail_q <= 1'b0;
		end
		else
		begin
			stcBusy_q <= link.stcRunning;
			if (link.stcDestReq)
				stcFail_q <= 1'b1;
			else if (stcStart_q)
				stcFail_q <= 1'b0;
		end
	end

	// cause: hardware set wins over software clear (write of ones)
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cause_q <= 6'h01;
		else if (wr && wbAdr == `REU_CAUSE_ADDR)
			cause_q <= (cause_q & ~wbDatI[5:0]) | evt;
		else
			cause_q <= cause_q | evt;
	end

	// interrupt status cleared by read; a same-cycle event survives
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irqStat_q <= '0;
		else if (rd && wbAdr == `REU_IRQ_STAT_ADDR)
			irqStat_q <= evt;
		else
			irqStat_q <= irqStat_q | evt;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq_q <= 1'b0;
			funcResetOut_q <= 1'b0;
			safeReq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(irqStat_q & irqMask_q);
			funcResetOut_q <= state_q == REU_FRESET;
			safeReq_q <= safeEvt && state_q == REU_RUN;
		end
	end

	assign irq = irq_q;
	assign safeModeReq = safeReq_q;
	assign link.funcResetOut = funcResetOut_q;
	assign link.destResetOut = destResetOut_q;
	assign link.stcStart = stcStart_q;
	assign link.pinMuxReset = pinRst_q;
endmodule // reu_reset_unit

/* File: logic/reu_source_end.sv */
`include "reu_defs.svh"
// reset sources and self-test controller end
module reu_source_end
	import reu_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // power-on reset
	input wire logic [`REU_NUM_SRC-1:0] userFuncEvent, // functional reset requests
	input wire logic userExtReset, // external reset request
	input wire logic userTestFail, // self-test outcome to inject
	input wire logic userRecFault, // recoverable fault
	output logic testDone, // self-test finished pulse
	output logic inReset, // functional or destructive reset active
	output logic pinsReset, // pin multiplexing held in reset
	reu_if.src link // reset unit
);
	reu_count_t testCnt_q;
	logic running_q, destReq_q, done_q, started_q;
	logic [`REU_NUM_SRC-1:0] evt_q;
	logic ext_q, rf_q, inRst_q, pins_q;

	// self-test runs on power-on and on each start from the reset unit that finds it idle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			running_q <= 1'b0;
			started_q <= 1'b0;
			testCnt_q <= 8'h00;
			destReq_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			destReq_q <= 1'b0;
			done_q <= 1'b0;
			if (!running_q && (link.stcStart || !started_q))
			begin
				running_q <= 1'b1;
				started_q <= 1'b1;
				testCnt_q <= `REU_TEST_CYC;
			end
			else if (running_q && testCnt_q == 8'h00)
			begin
				running_q <= 1'b0;
				done_q <= 1'b1;
				destReq_q <= userTestFail;
			end
			else if (running_q)
				testCnt_q <= testCnt_q - 8'h01;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			evt_q <= '0;
			ext_q <= 1'b0;
			rf_q <= 1'b0;
			inRst_q <= 1'b0;
			pins_q <= 1'b0;
		end
		else
		begin
			evt_q <= userFuncEvent;
			ext_q <= userExtReset;
			rf_q <= userRecFault;
			inRst_q <= link.funcResetOut || link.destResetOut;
			pins_q <= link.pinMuxReset || link.destResetOut;
		end
	end

	assign link.funcEvent = evt_q;
	assign link.extReset = ext_q;
	assign link.stcDestReq = destReq_q;
	assign link.stcUnrecFault = destReq_q;
	assign link.stcRecFault = rf_q;
	assign link.stcRunning = running_q;
	assign testDone = done_q;
	assign inReset = inRst_q;
	assign pinsReset = pins_q;
endmodule // reu_source_end

/* File: test/reu_assertions.sv */
`include "reu_defs.svh"
module reu_assertions
(
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [`REU_NUM_SRC-1:0] funcEvent, // requests
	input wire logic extReset, // ext
	input wire logic stcDestReq, // fail
	input wire logic stcUnrecFault, // uf
	input wire logic stcRecFault, // rf
	input wire logic stcRunning, // busy
	input wire logic stcStart, // start
	input wire logic funcResetOut, // func
	input wire logic destResetOut, // dest
	input wire logic pinMuxReset // pins
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a normal destructive pulse is short, so a long one means lock
	logic [7:0] heldCnt_q;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			heldCnt_q <= 8'h00;
		else if (!destResetOut)
			heldCnt_q <= 8'h00;
		else if (heldCnt_q != 8'hFF)
			heldCnt_q <= heldCnt_q + 8'h01;
	a_uf_mirrors_req: assert property (stcUnrecFault == stcDestReq)
		else $error("uf line differs");
	a_ext_gives_dest: assert property ($rose(extReset) |-> ##[1:8] destResetOut)
		else $error("no reset after ext");
	a_fail_gives_dest: assert property ($rose(stcDestReq) |-> ##[1:8] destResetOut)
		else $error("no reset after fail");
	a_start_runs_test: assert property (stcStart |-> ##[1:3] stcRunning)
		else $error("test not running");
	a_rf_no_reset: assert property ((!stcDestReq && !extReset && !(|funcEvent)) [*3] ##0
		(stcRecFault && !destResetOut) |=> !destResetOut)
		else $error("rf caused reset");
	a_func_pulse_len: assert property ($rose(funcResetOut) |-> funcResetOut [*4])
		else $error("short func reset");
	a_no_both_resets: assert property (!(funcResetOut && destResetOut))
		else $error("both resets");
	a_lock_holds: assert property (heldCnt_q == 8'h64 |-> ##1 destResetOut [*8])
		else $error("lock released");
	cover property ($rose(destResetOut));
	cover property (|funcEvent);
	cover property (heldCnt_q == 8'h64);
	cover property ($rose(pinMuxReset));
endmodule // reu_assertions

/* File: test/tb_top.sv */
`include "reu_defs.svh"
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s exp %0h got %0h", w, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CNT = `REU_COUNTERS_ADDR;
	localparam logic [7:0] CAUSE = `REU_CAUSE_ADDR;
	logic clk, rst, wbCyc, wbStb, wbWe, wbAck, wbErr, irq, safeModeReq;
	logic [7:0] wbAdr;
	logic [31:0] wbDatI, wbDatO, rngState;
	logic [3:0] wbSel, userFuncEvent;
	logic userExtReset, userTestFail, userRecFault, testDone, inReset, pinsReset;
	logic [64:0] expQueue[$];
	logic [64:0] x;
	int miscompares, n_compared, nSafe, nDone;
	reu_if link ();
	reu_reset_unit i_reu_reset_unit (.clk(clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAck(wbAck), .wbErr(wbErr), .irq(irq),
		.safeModeReq(safeModeReq), .link(link));
	reu_source_end i_reu_source_end (.clk(clk), .rst(rst), .userFuncEvent(userFuncEvent),
		.userExtReset(userExtReset), .userTestFail(userTestFail), .userRecFault(userRecFault),
		.testDone(testDone), .inReset(inReset), .pinsReset(pinsReset), .link(link));
	reu_assertions i_reu_assertions (.clk(clk), .rst(rst), .funcEvent(link.funcEvent),
		.extReset(link.extReset), .stcDestReq(link.stcDestReq), .stcUnrecFault(link.stcUnrecFault),
		.stcRecFault(link.stcRecFault), .stcRunning(link.stcRunning), .stcStart(link.stcStart),
		.funcResetOut(link.funcResetOut), .destResetOut(link.destResetOut), .pinMuxReset(link.pinMuxReset));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic end_sim();
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// entered right after an edge; holds the request until ack or err, or for at most 50 cycles
	task automatic wbAccess(input logic [7:0] a, input logic we, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e, input logic err);
		int n;
		expQueue.push_back({err, m, e});
		wbAdr <= a;
		wbWe <= we;
		wbDatI <= d;
		wbSel <= 4'hF;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
		if (wbAck !== 1'b1 && wbErr !== 1'b1)
			miscompares++;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbAccess(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wbAccess(a, 1'b0, 32'h0, m, e, 1'b0);
	endtask
	// a destructive reset and its self-test may leave a gap, so wait for a quiet run
	task automatic settle();
		int n, q;
		n = 0;
		q = 0;
		while (q < 6 && n < 600)
		begin
			@(posedge clk);
			n++;
			q = (inReset !== 1'b0 || link.stcRunning !== 1'b0) ? 0 : q + 1;
		end
	endtask
	task automatic fire(input logic [3:0] ev, input logic ext);
		userFuncEvent <= ev;
		userExtReset <= ext;
		@(posedge clk);
		userFuncEvent <= 4'h0;
		userExtReset <= 1'b0;
		settle();
	endtask
	always @(posedge clk)
	begin
		if (safeModeReq === 1'b1)
			nSafe++;
		if (testDone === 1'b1)
			nDone++;
		if ((wbAck === 1'b1 || wbErr === 1'b1) && expQueue.size() > 0)
		begin
			x = expQueue.pop_front();
			`CHK("bus error", x[64], wbErr)
			`CHK("read data", x[31:0], wbDatO & x[63:32])
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim();
	end
	initial
	begin
		{rst, wbCyc, wbStb, wbWe, userExtReset, userTestFail, userRecFault} = 7'h40;
		{wbAdr, wbDatI, wbSel, userFuncEvent} = '0;
		rngState = 32'h14;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd(CAUSE, 32'hFF, 32'h01);
		wr(CAUSE, 32'h3F);
		rd(CAUSE, 32'hFF, 32'h00);
		rd(`REU_IRQ_STAT_ADDR, 32'h0, 32'h0);
		repeat (3) fire(4'h1, 1'b0);
		rd(CNT, 32'hFFFF, 32'h0);
		`CHK("irq masked", 1'b0, irq)
		wr(`REU_IRQ_MASK_ADDR, 32'h3F);
		repeat (2) @(posedge clk);
		`CHK("irq raised", 1'b1, irq)
		rd(`REU_IRQ_STAT_ADDR, 32'h08, 32'h08);
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		wr(`REU_IRQ_MASK_ADDR, 32'h0);
		repeat (3)
		begin
			rngState = nextRand(rngState);
			wr(`REU_DEST_THRESH_ADDR, rngState);
			rd(`REU_DEST_THRESH_ADDR, 32'hFF, {24'h0, rngState[7:0]});
		end
		wr(`REU_DEST_THRESH_ADDR, 32'h0);
		wr(`REU_FUNC_THRESH_ADDR, 32'h3);
		rd(`REU_FUNC_THRESH_ADDR, 32'hFF, 32'h3);
		for (int i = 1; i <= 3; i++)
		begin
			fire(4'h2, 1'b0);
			rd(CNT, 32'hFFFF, i < 3 ? 32'(i) : 32'h100);
		end
		rd(CAUSE, 32'h10, 32'h10);
		fire(4'h8, 1'b0);
		rd(CNT, 32'hFFFF, 32'h101);
		wr(`REU_CLEAR_ADDR, 32'h1);
		rd(CNT, 32'hFFFF, 32'h100);
		wr(`REU_CLEAR_ADDR, 32'h2);
		rd(CNT, 32'hFFFF, 32'h0);
		rngState = nextRand(rngState);
		wr(`REU_ALT_REACT_ADDR, 32'h1 << rngState[1:0]);
		nSafe = 0;
		fire(4'h1 << rngState[1:0], 1'b0);
		`CHK("safe mode", 1, nSafe)
		rd(CNT, 32'hFFFF, 32'h0);
		rd(CAUSE, 32'h20, 32'h20);
		wr(`REU_ALT_REACT_ADDR, 32'h0);
		for (int i = 1; i >= 0; i--)
		begin
			wr(`REU_PERIPH_RST_ADDR, 32'(i));
			repeat (3) @(posedge clk);
			`CHK("pins reset", 1'(i), pinsReset)
		end
		wbAccess(`REU_STC_CTRL_ADDR, 1'b1, 32'h1, 32'h0, 32'h0, 1'b1);
		wbAccess(8'h30, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
		userRecFault <= 1'b1;
		@(posedge clk);
		userRecFault <= 1'b0;
		settle();
		rd(CNT, 32'hFFFF, 32'h0);
		wr(`REU_DEST_THRESH_ADDR, 32'h2);
		nDone = 0;
		fire(4'h0, 1'b1);
		`CHK("test done", 1, nDone)
		rd(CNT, 32'hFFFF, 32'h100);
		rd(`REU_STC_STAT_ADDR, 32'h3, 32'h0);
		userTestFail <= 1'b1;
		wr(`REU_STC_KEY_ADDR, `REU_KEY1);
		wr(`REU_STC_KEY_ADDR, `REU_KEY2);
		wr(`REU_STC_CTRL_ADDR, 32'h1);
		repeat (150) @(posedge clk);
		`CHK("held in reset", 1'b1, link.destResetOut)
		rd(`REU_STC_STAT_ADDR, 32'h2, 32'h2);
		rst <= 1'b1;
		userTestFail <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd(CNT, 32'hFFFF, 32'h0);
		rd(CAUSE, 32'hFF, 32'h01);
		end_sim();
	end
endmodule // tb_top
